// ### sfw_flash_seq.v
// command decoder, wrap setting, page program and erase sequencer of a flash
`timescale 1ns/100ps
`include "sfw_map.vh"

// Notes on behaviour
// - wrap command: opcode, 24 ignored bits, config byte
// - only bits six to four of wrap byte used
// - length field picks 8/16/32/64 byte section
// - stored wrap applies until replaced
// - disable bit one means linear reads
// - reset sets wrap disable bit
// - program rejected unless write enable latch set
// - program: opcode, 24-bit address, 1..256 bytes
// - program address wraps within the page
// - program cycle starts only on whole final byte; bytes are written as they arrive
// - program cycle shows busy until done
// - protected targets are skipped
// - quad program also needs quad enable bit
// - 4 KB erase needs latch, fills ones
// - 32 KB erase needs latch, fills ones
// - 64 KB erase needs latch, fills ones
// - erase runs only if select rises after address
// - erase cycle shows busy until done
// - erase completion clears write enable latch
// - wrapped read returns to section start
// - commands during busy are ignored
module sfw_flash_seq #(
    parameter PP_CYC = `SFW_US_CYC(`SFW_PP_TIME_US),
    parameter SE_CYC = `SFW_US_CYC(`SFW_SE_TIME_US),
    parameter BE32_CYC = `SFW_US_CYC(`SFW_BE32_TIME_US),
    parameter BE64_CYC = `SFW_US_CYC(`SFW_BE64_TIME_US)
) (
    input wire i_clock, // system clock
    input wire i_arst_n, // async reset, active low
    input wire i_cs_n, // chip select pin, active low
    input wire i_sclk, // serial clock pin
    input wire i_serial_in_line, // single-line data pin
    input wire [3:0] i_quad_line, // quad lines quad_line_0..quad_line_3
    input wire i_write_enable_latch_set, // pulse: write enable command seen
    input wire i_quad_enable_bit, // quad enable configuration
    input wire i_target_protected, // addressed target locked or protected
    input wire i_wr_ready, // memory array accepts a write word
    input wire [7:0] i_rd_addr_lo, // low address of wrapped read counter
    input wire [7:0] i_rd_start, // wrapped read start address low
    output reg o_busy, // busy flag
    output reg o_write_enable_latch, // write enable latch
    output reg o_wrap_disable_bit, // wrap disabled
    output reg [1:0] o_wrap_length_field, // wrap section length code
    output reg [7:0] o_rd_next_lo, // next wrapped read address low
    output reg o_wr_valid, // program byte valid toward array
    output reg [23:0] o_wr_addr, // program byte address
    output reg [7:0] o_wr_data, // program byte data
    output reg o_erase_pulse, // erase start pulse
    output reg [1:0] o_erase_kind, // 0 4KB, 1 32KB, 2 64KB
    output reg [23:0] o_erase_addr // erase base address
);
    localparam ST_OP = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_WRAP = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_IGN = 3'd4;

    // two-flop synchronisers; the first stage feeds only the second
    reg [6:0] s1_q;
    reg [6:0] s2_q;
    reg sclk_prev_q;
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // idle pin levels: select high, clock low, so no false edge
            s1_q <= 7'h40;
            s2_q <= 7'h40;
            sclk_prev_q <= 1'b0;
        end else begin
            s1_q <= {i_cs_n, i_sclk, i_serial_in_line, i_quad_line};
            s2_q <= s1_q;
            sclk_prev_q <= s2_q[5];
        end
    end
    wire cs_n = s2_q[6];
    wire rise = s2_q[5] & ~sclk_prev_q & ~cs_n;
    reg cs_prev_q;
    wire cs_rise = cs_n & ~cs_prev_q;

    // section length mask from the wrap length code
    function [7:0] wrap_mask;
        input [1:0] len;
        begin
            case (len)
                2'b00: wrap_mask = 8'h07;
                2'b01: wrap_mask = 8'h0F;
                2'b10: wrap_mask = 8'h1F;
                default: wrap_mask = 8'h3F;
            endcase
        end
    endfunction

    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_next_lo <= 8'h00;
        end else if (o_wrap_disable_bit) begin
            o_rd_next_lo <= i_rd_addr_lo + 8'h01;
        end else begin
            o_rd_next_lo <= (i_rd_start & ~wrap_mask(o_wrap_length_field)) |
                ((i_rd_addr_lo + 8'h01) & wrap_mask(o_wrap_length_field));
        end
    end

    reg [2:0] st_q;
    reg [7:0] op_q;
    reg [7:0] sh_q;
    reg [4:0] cnt_q;
    reg quad_q;
    reg [23:0] addr_q;
    reg have_byte_q;
    reg [20:0] timer_q;
    reg prog_run_q;
    // two-entry buffer between the shifter and the array port
    reg [31:0] fifo_q [0:1];
    reg [1:0] fcnt_q;
    reg fwp_q;
    reg frp_q;
    reg push;
    reg [31:0] push_word;
    wire pop = o_wr_valid & i_wr_ready;
    wire fifo_full = fcnt_q == 2'd2;
    wire [4:0] bits_per = quad_q ? 5'd4 : 5'd1;
    wire [7:0] sh_nx = quad_q ? {sh_q[3:0], s2_q[3:0]} :
        {sh_q[6:0], s2_q[4]};
    wire [7:0] op_nx = {sh_q[6:0], s2_q[4]};
    wire is_erase = (op_q == `SFW_OP_SE) | (op_q == `SFW_OP_BE32) |
        (op_q == `SFW_OP_BE64);

    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_prev_q <= 1'b1;
            st_q <= ST_OP;
            op_q <= 8'h00;
            sh_q <= 8'h00;
            cnt_q <= 5'd0;
            quad_q <= 1'b0;
            addr_q <= 24'h000000;
            have_byte_q <= 1'b0;
            timer_q <= 21'd0;
            prog_run_q <= 1'b0;
            o_busy <= 1'b0;
            o_write_enable_latch <= 1'b0;
            {o_wrap_length_field, o_wrap_disable_bit} <= `SFW_WRAP_RESET;
            o_erase_pulse <= 1'b0;
            o_erase_kind <= 2'd0;
            o_erase_addr <= 24'h000000;
        end else begin
            cs_prev_q <= cs_n;
            o_erase_pulse <= 1'b0;
            if (i_write_enable_latch_set && !o_busy)
                o_write_enable_latch <= 1'b1;
            if (o_busy) begin
                if (timer_q != 21'd0) begin
                    timer_q <= timer_q - 21'd1;
                end else if (!prog_run_q || fcnt_q == 2'd0) begin
                    o_busy <= 1'b0;
                    o_write_enable_latch <= 1'b0;
                    prog_run_q <= 1'b0;
                end
            end
            if (cs_n) begin
                st_q <= ST_OP;
                cnt_q <= 5'd0;
                quad_q <= 1'b0;
                if (cs_rise && !o_busy && cnt_q == 5'd0) begin
                    // rise only on a byte boundary
                    if (st_q == ST_DATA && have_byte_q) begin
                        o_busy <= 1'b1;
                        prog_run_q <= 1'b1;
                        timer_q <= PP_CYC[20:0];
                    end else if (st_q == ST_IGN && is_erase &&
                            have_byte_q) begin
                        o_busy <= 1'b1;
                        o_erase_pulse <= 1'b1;
                        o_erase_addr <= addr_q;
                        if (op_q == `SFW_OP_SE) begin
                            o_erase_kind <= 2'd0;
                            timer_q <= SE_CYC[20:0];
                        end else if (op_q == `SFW_OP_BE32) begin
                            o_erase_kind <= 2'd1;
                            timer_q <= BE32_CYC[20:0];
                        end else begin
                            o_erase_kind <= 2'd2;
                            timer_q <= BE64_CYC[20:0];
                        end
                    end
                end
                have_byte_q <= 1'b0;
            end else if (rise && !(st_q == ST_DATA && fifo_full)) begin
                case (st_q)
                    ST_OP: begin
                        sh_q <= op_nx;
                        if (cnt_q == 5'd7) begin
                            cnt_q <= 5'd0;
                            op_q <= op_nx;
                            quad_q <= op_nx == `SFW_OP_QPP;
                            if (o_busy)
                                st_q <= ST_IGN;
                            else if (op_nx == `SFW_OP_WRAP)
                                st_q <= ST_ADDR;
                            else if ((op_nx == `SFW_OP_PP ||
                                    (op_nx == `SFW_OP_QPP &&
                                    i_quad_enable_bit)) &&
                                    o_write_enable_latch)
                                st_q <= ST_ADDR;
                            else if ((op_nx == `SFW_OP_SE ||
                                    op_nx == `SFW_OP_BE32 ||
                                    op_nx == `SFW_OP_BE64) &&
                                    o_write_enable_latch)
                                st_q <= ST_ADDR;
                            else
                                st_q <= ST_IGN;
                        end else begin
                            cnt_q <= cnt_q + 5'd1;
                        end
                    end
                    ST_ADDR: begin // msb first
                        addr_q <= quad_q ? {addr_q[19:0], s2_q[3:0]} :
                            {addr_q[22:0], s2_q[4]};
                        if (cnt_q + bits_per >= 5'd24) begin
                            cnt_q <= 5'd0;
                            if (op_q == `SFW_OP_WRAP) begin
                                st_q <= ST_WRAP;
                            end else if (is_erase) begin
                                st_q <= ST_IGN;
                                have_byte_q <= ~i_target_protected;
                            end else if (i_target_protected) begin
                                st_q <= ST_IGN;
                            end else begin
                                st_q <= ST_DATA;
                            end
                        end else begin
                            cnt_q <= cnt_q + bits_per;
                        end
                    end
                    ST_WRAP: begin
                        sh_q <= op_nx;
                        if (cnt_q == 5'd7) begin
                            cnt_q <= 5'd0;
                            st_q <= ST_IGN;
                            o_wrap_disable_bit <= op_nx[`SFW_WRAP_DIS_POS];
                            o_wrap_length_field <=
                                op_nx[`SFW_WRAP_LEN_HI:`SFW_WRAP_LEN_LO];
                        end else begin
                            cnt_q <= cnt_q + 5'd1;
                        end
                    end
                    ST_DATA: begin
                        sh_q <= sh_nx;
                        if (cnt_q + bits_per == 5'd8) begin
                            cnt_q <= 5'd0;
                            have_byte_q <= 1'b1;
                            addr_q[7:0] <= addr_q[7:0] + 8'h01;
                        end else begin
                            cnt_q <= cnt_q + bits_per;
                        end
                    end
                    ST_IGN: begin
                        cnt_q <= (cnt_q == 5'd7) ? 5'd0 : cnt_q + 5'd1;
                        if (is_erase)
                            have_byte_q <= 1'b0; // extra bits drop it
                    end
                    default: st_q <= ST_OP;
                endcase
            end
        end
    end

    // bytes go to the array as they arrive; a late cs_n rise still wrote
    // them, which is the trade for not holding a whole page here
    always @* begin
        push = !cs_n && rise && st_q == ST_DATA && !fifo_full &&
            cnt_q + bits_per == 5'd8;
        push_word = {addr_q, sh_nx};
    end

    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fcnt_q <= 2'd0;
            fwp_q <= 1'b0;
            frp_q <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_addr <= 24'h000000;
            o_wr_data <= 8'h00;
        end else begin
            if (push) begin
                fifo_q[fwp_q] <= push_word;
                fwp_q <= ~fwp_q;
            end
            if (!o_wr_valid || pop) begin
                if (fcnt_q != 2'd0 && !(fcnt_q == 2'd1 && pop)) begin
                    o_wr_valid <= 1'b1;
                    {o_wr_addr, o_wr_data} <= fifo_q[frp_q];
                    frp_q <= ~frp_q;
                end else begin
                    o_wr_valid <= 1'b0;
                end
            end
            fcnt_q <= fcnt_q + {1'b0, push} -
                {1'b0, (!o_wr_valid || pop) && fcnt_q != 2'd0 &&
                !(fcnt_q == 2'd1 && pop)};
        end
    end
endmodule

// ### sfw_map.vh
// opcodes, wrap field layout, reset values and cycle timing for the sequencer
`ifndef SFW_MAP_VH
`define SFW_MAP_VH
`define SFW_OP_WRAP 8'h77
`define SFW_OP_PP 8'h02
`define SFW_OP_QPP 8'h32
`define SFW_OP_SE 8'h20
`define SFW_OP_BE32 8'h52
`define SFW_OP_BE64 8'hD8
`define SFW_ADDR_BITS 24
`define SFW_WRAP_DIS_POS 4
`define SFW_WRAP_LEN_HI 6
`define SFW_WRAP_LEN_LO 5
`define SFW_WRAP_RESET 3'h1
`define SFW_CLK_MHZ 10
`define SFW_PP_TIME_US 40
`define SFW_SE_TIME_US 450
`define SFW_BE32_TIME_US 1200
`define SFW_BE64_TIME_US 1600
`define SFW_US_CYC(t) ((t) * `SFW_CLK_MHZ)
`endif

// ### sfw_asserts.sv
// property checker for the flash command sequencer
`timescale 1ns/100ps
module sfw_asserts (
    input wire i_clock, // clock
    input wire i_arst_n, // reset
    input wire i_cs_n, // select
    input wire i_wr_ready, // array ready
    input wire [7:0] i_rd_addr_lo, // read addr
    input wire [7:0] i_rd_start, // read start
    input wire o_busy, // busy
    input wire o_write_enable_latch, // latch
    input wire o_wrap_disable_bit, // wrap off
    input wire [1:0] o_wrap_length_field, // wrap len
    input wire [7:0] o_rd_next_lo, // next addr
    input wire o_wr_valid, // byte valid
    input wire [23:0] o_wr_addr, // byte addr
    input wire [7:0] o_wr_data, // byte data
    input wire o_erase_pulse // erase start
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    reg ok_q;
    reg [7:0] exp_q;
    wire [7:0] msk = (8'h08 << o_wrap_length_field) - 8'h01;
    wire [7:0] inc = i_rd_addr_lo + 8'h01;
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ok_q <= 1'b0;
            exp_q <= 8'h00;
        end else begin
            ok_q <= 1'b1;
            exp_q <= o_wrap_disable_bit ? inc :
                (i_rd_start & ~msk) | (inc & msk);
        end
    end
    chk_rd_wrap: assert property (ok_q |-> o_rd_next_lo == exp_q)
        else $error("wrapped read address wrong");
    chk_wrap_rst: assert property
        ($rose(i_arst_n) |-> o_wrap_disable_bit)
        else $error("wrap not disabled after reset");
    chk_wrap_busy: assert property (o_busy |=>
        $stable({o_wrap_disable_bit, o_wrap_length_field}))
        else $error("wrap setting changed while busy");
    chk_busy_wel: assert property
        ($rose(o_busy) |-> o_write_enable_latch)
        else $error("cycle started without latch");
    chk_busy_min: assert property ($rose(o_busy) |-> o_busy [*8])
        else $error("busy dropped early");
    chk_busy_cs: assert property
        ($rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2))
        else $error("busy rose with select low");
    chk_wel_clear: assert property ($fell(o_busy) |-> !o_write_enable_latch)
        else $error("latch still set after cycle");
    chk_wv_hold: assert property
        (o_wr_valid && !i_wr_ready |=> o_wr_valid &&
        $stable(o_wr_addr) && $stable(o_wr_data))
        else $error("program byte lost under stall");
    cov_erase: cover property (o_erase_pulse);
    cov_busy: cover property ($rose(o_busy));
    cov_stall: cover property (o_wr_valid && !i_wr_ready);
endmodule

// ### sfw_host.sv
// host side serial controller model driving select, clock and data
`timescale 1ns/100ps
module sfw_host (
    input wire i_clock, // system clock
    output reg o_cs_n, // chip select
    output reg o_sclk, // serial clock
    output reg o_si, // single data line
    output reg [3:0] o_quad // quad lines
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
        o_quad = 4'h0;
    end
    // msb first; sclk idles low, eight clocks a bit
    task send(input [31:0] v, input integer n, input q);
        integer i;
        begin
            for (i = n - 1; i >= 0; i = i - 1) begin
                o_cs_n <= 1'b0;
                if (q) o_quad <= v[4*i +: 4];
                else o_si <= v[i];
                repeat (4) @(posedge i_clock);
                o_sclk <= 1'b1;
                repeat (4) @(posedge i_clock);
                o_sclk <= 1'b0;
            end
        end
    endtask
    // released lines flip so a stale level is never mistaken for data
    task stop;
        begin
            repeat (4) @(posedge i_clock);
            o_cs_n <= 1'b1;
            o_si <= ~o_si;
            o_quad <= ~o_quad;
            repeat (8) @(posedge i_clock);
        end
    endtask
endmodule

// ### test_sfw_flash_seq.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module test_sfw_flash_seq;
    reg clk, rst_n, wset, qe, prot, rdy;
    reg [7:0] rd_lo, rd_st;
    reg [31:0] seed;
    wire cs_n, sclk, si, busy, write_enable_latch, wdis, wv, ep;
    wire [3:0] qd;
    wire [1:0] wlen, ek;
    wire [7:0] wd, nxt;
    wire [23:0] wa, eaddr;
    integer n_mismatch, checked, k;
    reg [31:0] wq[$];
    reg [25:0] eq[$];
    reg [31:0] we;
    reg [25:0] ee;
    reg [7:0] nx_e;
    reg nv;
    // section mask and increment for the expected next read address
    wire [7:0] wm = (8'h08 << wlen) - 8'h01;
    wire [7:0] rd_inc = rd_lo + 8'h01;
    sfw_host h (.i_clock(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
        .o_quad(qd));
    sfw_flash_seq #(.PP_CYC(400), .SE_CYC(450), .BE32_CYC(500),
        .BE64_CYC(550)) DUT (.i_clock(clk), .i_arst_n(rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_serial_in_line(si), .i_quad_line(qd),
        .i_write_enable_latch_set(wset), .i_quad_enable_bit(qe),
        .i_target_protected(prot), .i_wr_ready(rdy), .i_rd_addr_lo(rd_lo),
        .i_rd_start(rd_st), .o_busy(busy), .o_write_enable_latch(write_enable_latch),
        .o_wrap_disable_bit(wdis), .o_wrap_length_field(wlen),
        .o_rd_next_lo(nxt), .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd),
        .o_erase_pulse(ep), .o_erase_kind(ek), .o_erase_addr(eaddr));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wrap(input [7:0] b);
        begin
            h.send(8'h77, 8, 0);
            h.send(seed, 24, 0);
            h.send(b, 8, 0);
            h.stop;
        end
    endtask
    task setwel;
        begin
            @(posedge clk);
            wset <= 1'b1;
            @(posedge clk);
            wset <= 1'b0;
            repeat (2) @(posedge clk);
            check("wel", write_enable_latch, 1);
        end
    endtask
    task go(input acc);
        integer t;
        begin
            check("busy", busy, acc);
            if (acc) begin
                wrap(8'h00);
                check("busywrap", {wdis, wlen}, 3'h4);
                for (t = 0; busy && t < 2000; t = t + 1) @(posedge clk);
                if (busy) begin
                    check("timeout", busy, 0);
                    final_report;
                end
                check("welclr", write_enable_latch, 0);
            end
        end
    endtask
    task prog(input [7:0] op, input [23:0] a, input integer n, input acc);
        integer i;
        reg q;
        begin
            q = (op == 8'h32);
            h.send(op, 8, 0);
            h.send(a, q ? 6 : 24, q);
            for (i = 0; i < n; i = i + 1) begin
                if (acc) wq.push_back({a[23:8], a[7:0] + i[7:0],
                    a[7:0] ^ 8'h5A ^ i[7:0]});
                h.send(a[7:0] ^ 8'h5A ^ i[7:0], q ? 2 : 8, q);
            end
            h.stop;
            go(acc);
        end
    endtask
    task er(input [7:0] op, input [23:0] a, input [1:0] kd, input acc,
        input xb);
        begin
            if (acc) eq.push_back({kd, a});
            h.send(op, 8, 0);
            h.send(a, 24, 0);
            if (xb) h.send(4'h3, 4, 0);
            h.stop;
            go(acc);
        end
    endtask
    // results are matched in arrival order against the driver's notes
    always @(posedge clk) begin
        if (wv && rdy) begin
            we = wq.size() ? wq.pop_front() : 32'hX;
            check("wbyte", {wa, wd}, we);
        end
        if (ep) begin
            ee = eq.size() ? eq.pop_front() : 26'hX;
            check("erase", {ek, eaddr}, ee);
        end
        if (nv === 1'b1)
            check("next", nxt, nx_e);
        nv <= rst_n;
        nx_e <= wdis ? rd_inc : (rd_st & ~wm) | (rd_inc & wm);
    end
    always @(posedge clk) begin
        seed <= lfsr(seed);
        rdy <= seed[0] | seed[1];
        rd_lo <= seed[15:8];
        rd_st <= seed[23:16];
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        check("timeout", 1, 0);
        final_report;
    end
    initial begin
        n_mismatch = 0;
        checked = 0;
        seed = 32'h1587;
        rst_n = 1'b0;
        {wset, qe, prot} = 3'b000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("wrap", {wdis, wlen}, 3'h4);
        for (k = 0; k < 4; k = k + 1) begin
            wrap({1'b1, k[1:0], 1'b0, seed[3:0]});
            check("wrap", {wdis, wlen}, {1'b0, k[1:0]});
        end
        wrap(8'h9F);
        check("wdis", wdis, 1);
        prog(8'h02, 24'h0012F0, 2, 0);
        setwel;
        prog(8'h02, 24'h1234FE, 3, 1);
        setwel;
        prog(8'h32, 24'h00AB10, 2, 0);
        qe <= 1'b1;
        prog(8'h32, 24'h00AB10, 2, 1);
        for (k = 0; k < 3; k = k + 1) begin
            setwel;
            er(24'hD85220 >> (8 * k), {8'h01 + k[7:0], 16'h0000},
                k[1:0], 1, 0);
        end
        setwel;
        er(8'h20, 24'h020000, 0, 0, 1);
        prot <= 1'b1;
        er(8'hD8, 24'h030000, 2, 0, 0);
        prot <= 1'b0;
        repeat (20) @(posedge clk);
        check("left", wq.size() + eq.size(), 0);
        final_report;
    end
endmodule
bind sfw_flash_seq sfw_asserts u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_cs_n(i_cs_n), .i_wr_ready(i_wr_ready), .i_rd_addr_lo(i_rd_addr_lo),
    .i_rd_start(i_rd_start),
    .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch),
    .o_wrap_disable_bit(o_wrap_disable_bit),
    .o_wrap_length_field(o_wrap_length_field), .o_rd_next_lo(o_rd_next_lo),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_erase_pulse(o_erase_pulse));
